//--- rtl/mfc_regs.svh
// Constants for the multiply and program-flow execution block.
// Assumes inclusion by bare name from files under rtl/.
// What this block does
// - Integer multiplies write 16-bit product to product pair, set Z and C, 2 cycles.
// - Fractional multiplies write product shifted left one, set Z and C, 2 cycles.
// - Pointer jump loads PC from Z pointer, flags unchanged, 2 cycles.
// - Pointer call pushes return address, loads PC from Z, flags unchanged, 3 cycles.
// - Compare-skip-equal skips next instruction by PC plus 2 or 3; 1/2/3 cycles.
// - Register bit skips test one register bit, skip on clear or set, no flags.
// - I/O bit skips test one I/O register bit, skip on clear or set, no flags.
// - Branch-flag-set jumps to PC plus offset plus one when bit set; 1/2 cycles.
// - Branch-flag-clear jumps to PC plus offset plus one when bit clear, no flags.
// - Compares set Z,N,V,C,H without write-back in 1 cycle; carry form subtracts C.
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH

`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
`define STATUS_RESET 8'h00
`define PC_RESET 16'h0000
`define PRODUCT_RESET 16'h0000

`define CYC_MULTIPLY 2'h2
`define CYC_REL_JUMP 2'h2
`define CYC_PTR_JUMP 2'h2
`define CYC_ABS_JUMP 2'h3
`define CYC_REL_CALL 2'h3
`define CYC_PTR_CALL 2'h3
`define CYC_ABS_CALL 3'h4
`define CYC_RETURN 3'h4
`define CYC_SINGLE 3'h1
`define CYC_BRANCH_TAKEN 3'h2
`define CYC_SKIP_ONE 3'h2
`define CYC_SKIP_TWO 3'h3

`define PC_STEP_ONE 16'h0001
`define PC_STEP_TWO 16'h0002
`define PC_STEP_THREE 16'h0003

`endif

//--- rtl/mfc_pkg.sv
// Types shared by the multiply and program-flow execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package mfc_pkg;

    typedef enum logic [4:0] {
        OTHER_INSTRUCTION = 5'h00,
        UNSIGNED_MULTIPLY = 5'h01,
        SIGNED_MULTIPLY = 5'h02,
        SIGNED_BY_UNSIGNED_MULTIPLY = 5'h03,
        FRACTIONAL_UNSIGNED_MULTIPLY = 5'h04,
        FRACTIONAL_SIGNED_MULTIPLY = 5'h05,
        FRACTIONAL_MIXED_MULTIPLY = 5'h06,
        RELATIVE_JUMP = 5'h07,
        POINTER_JUMP = 5'h08,
        ABSOLUTE_JUMP = 5'h09,
        RELATIVE_SUBROUTINE_CALL = 5'h0A,
        POINTER_SUBROUTINE_CALL = 5'h0B,
        ABSOLUTE_SUBROUTINE_CALL = 5'h0C,
        SUBROUTINE_RETURN = 5'h0D,
        INTERRUPT_RETURN = 5'h0E,
        COMPARE_SKIP_EQUAL = 5'h0F,
        REGISTER_COMPARE = 5'h10,
        REGISTER_COMPARE_WITH_CARRY = 5'h11,
        IMMEDIATE_COMPARE = 5'h12,
        SKIP_REG_BIT_CLEAR = 5'h13,
        SKIP_REG_BIT_SET = 5'h14,
        SKIP_IO_BIT_CLEAR = 5'h15,
        SKIP_IO_BIT_SET = 5'h16,
        BRANCH_FLAG_SET = 5'h17,
        BRANCH_FLAG_CLEAR = 5'h18
    } opcode_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } exec_state_e;

endpackage

//--- rtl/mfc_multiplier.sv
// Combinational 8x8 multiplier with signed, unsigned and fractional forms.
// Assumes operands are stable in the cycle the instruction is accepted.
`timescale 1ns/100ps
module mfc_multiplier (
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic signedA,
    input wire logic signedB,
    input wire logic fractional,
    output logic [15:0] rawProduct,
    output logic [15:0] result,
    output logic carryOut,
    output logic zeroOut
);
    logic signed [8:0] extA;
    logic signed [8:0] extB;
    logic signed [17:0] fullProduct;

    always_comb
    begin
        extA = {signedA & opA[7], opA};
        extB = {signedB & opB[7], opB};
        fullProduct = extA * extB;
        rawProduct = fullProduct[15:0];
        result = fractional ? {rawProduct[14:0], 1'b0} : rawProduct;
        carryOut = rawProduct[15];
        zeroOut = (result == 16'h0000);
    end
endmodule

//--- rtl/mfc_comparator.sv
// Subtract-without-write unit producing compare flags.
// Assumes the caller merges flags into the status register.
`timescale 1ns/100ps
module mfc_comparator (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic borrowIn,
    output logic flagH,
    output logic flagV,
    output logic flagN,
    output logic flagZ,
    output logic flagC
);
    logic [8:0] diff;

    always_comb
    begin
        diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
        flagC = diff[8];
        flagN = diff[7];
        flagZ = (diff[7:0] == 8'h00);
        flagV = (minuend[7] & ~subtrahend[7] & ~diff[7])
            | (~minuend[7] & subtrahend[7] & diff[7]);
        flagH = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
            | (diff[3] & ~minuend[3]);
    end
endmodule

//--- rtl/multiply_and_flow_control.sv
// Execution of multiply, jump, call, return, compare, skip and flag branch instructions.
// Assumes operands come from logic on sys_clk and are valid with instrValid.
`timescale 1ns/100ps
`include "mfc_regs.svh"
module multiply_and_flow_control (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic instrValid,
    input wire mfc_pkg::opcode_e opcode,
    input wire logic [7:0] srcA,
    input wire logic [7:0] srcB,
    input wire logic [7:0] immK,
    input wire logic [2:0] bitSel,
    input wire logic [7:0] ioData,
    input wire logic [11:0] relOffset,
    input wire logic [15:0] absTarget,
    input wire logic [15:0] zPointer,
    input wire logic [15:0] stackData,
    input wire logic nextTwoWord,
    output logic busy,
    output logic done,
    output logic [15:0] pcOut,
    output logic [7:0] statusOut,
    output logic [15:0] productOut,
    output logic productWrite,
    output logic [15:0] pushAddr,
    output logic pushStrobe,
    output logic popStrobe
);
    mfc_pkg::exec_state_e stateQ, stateD;
    logic [1:0] cntQ, cntD;
    logic doneQ, doneD;
    logic [15:0] pcQ, pcD;
    logic [7:0] statusQ, statusD;
    logic [15:0] productQ, productD;
    logic productWriteQ, productWriteD;
    logic [15:0] pushAddrQ, pushAddrD;
    logic pushQ, pushD;
    logic popQ, popD;

    logic accept;
    logic isMul;
    logic mulSignedA;
    logic mulSignedB;
    logic mulFrac;
    logic [15:0] mulRaw;
    logic [15:0] mulResult;
    logic mulC;
    logic mulZ;
    logic [7:0] cmpB;
    logic cmpBorrow;
    logic cmpH, cmpV, cmpN, cmpZ, cmpC;
    logic [15:0] offsetExt;
    logic skipCond;
    logic branchTaken;
    logic [2:0] cycles;

    function automatic logic is_multiply(input mfc_pkg::opcode_e op);
        is_multiply = (op == mfc_pkg::UNSIGNED_MULTIPLY)
            || (op == mfc_pkg::SIGNED_MULTIPLY)
            || (op == mfc_pkg::SIGNED_BY_UNSIGNED_MULTIPLY)
            || (op == mfc_pkg::FRACTIONAL_UNSIGNED_MULTIPLY)
            || (op == mfc_pkg::FRACTIONAL_SIGNED_MULTIPLY)
            || (op == mfc_pkg::FRACTIONAL_MIXED_MULTIPLY);
    endfunction

    function automatic logic [2:0] cycle_count(input mfc_pkg::opcode_e op, input logic skip,
        input logic taken, input logic twoWord);
        case (op)
            mfc_pkg::RELATIVE_JUMP: cycle_count = {1'b0, `CYC_REL_JUMP};
            mfc_pkg::POINTER_JUMP: cycle_count = {1'b0, `CYC_PTR_JUMP};
            mfc_pkg::ABSOLUTE_JUMP: cycle_count = {1'b0, `CYC_ABS_JUMP};
            mfc_pkg::RELATIVE_SUBROUTINE_CALL: cycle_count = {1'b0, `CYC_REL_CALL};
            mfc_pkg::POINTER_SUBROUTINE_CALL: cycle_count = {1'b0, `CYC_PTR_CALL};
            mfc_pkg::ABSOLUTE_SUBROUTINE_CALL: cycle_count = `CYC_ABS_CALL;
            mfc_pkg::SUBROUTINE_RETURN: cycle_count = `CYC_RETURN;
            mfc_pkg::INTERRUPT_RETURN: cycle_count = `CYC_RETURN;
            mfc_pkg::COMPARE_SKIP_EQUAL, mfc_pkg::SKIP_REG_BIT_CLEAR,
            mfc_pkg::SKIP_REG_BIT_SET, mfc_pkg::SKIP_IO_BIT_CLEAR,
            mfc_pkg::SKIP_IO_BIT_SET:
                cycle_count = !skip ? `CYC_SINGLE : (twoWord ? `CYC_SKIP_TWO : `CYC_SKIP_ONE);
            mfc_pkg::BRANCH_FLAG_SET, mfc_pkg::BRANCH_FLAG_CLEAR:
                cycle_count = taken ? `CYC_BRANCH_TAKEN : `CYC_SINGLE;
            default: cycle_count = is_multiply(op) ? {1'b0, `CYC_MULTIPLY} : `CYC_SINGLE;
        endcase
    endfunction

    always_comb
    begin
        accept = instrValid && (stateQ == mfc_pkg::ST_IDLE);
        isMul = is_multiply(opcode);
        mulSignedA = (opcode == mfc_pkg::SIGNED_MULTIPLY)
            || (opcode == mfc_pkg::SIGNED_BY_UNSIGNED_MULTIPLY)
            || (opcode == mfc_pkg::FRACTIONAL_SIGNED_MULTIPLY)
            || (opcode == mfc_pkg::FRACTIONAL_MIXED_MULTIPLY);
        mulSignedB = (opcode == mfc_pkg::SIGNED_MULTIPLY)
            || (opcode == mfc_pkg::FRACTIONAL_SIGNED_MULTIPLY);
        mulFrac = (opcode == mfc_pkg::FRACTIONAL_UNSIGNED_MULTIPLY)
            || (opcode == mfc_pkg::FRACTIONAL_SIGNED_MULTIPLY)
            || (opcode == mfc_pkg::FRACTIONAL_MIXED_MULTIPLY);
        cmpB = (opcode == mfc_pkg::IMMEDIATE_COMPARE) ? immK : srcB;
        cmpBorrow = (opcode == mfc_pkg::REGISTER_COMPARE_WITH_CARRY) && statusQ[`FLAG_C];
        offsetExt = {{4{relOffset[11]}}, relOffset};
        case (opcode)
            mfc_pkg::COMPARE_SKIP_EQUAL: skipCond = (srcA == srcB);
            mfc_pkg::SKIP_REG_BIT_CLEAR: skipCond = !srcB[bitSel];
            mfc_pkg::SKIP_REG_BIT_SET: skipCond = srcB[bitSel];
            mfc_pkg::SKIP_IO_BIT_CLEAR: skipCond = !ioData[bitSel];
            mfc_pkg::SKIP_IO_BIT_SET: skipCond = ioData[bitSel];
            default: skipCond = 1'b0;
        endcase
        branchTaken = ((opcode == mfc_pkg::BRANCH_FLAG_SET) && statusQ[bitSel])
            || ((opcode == mfc_pkg::BRANCH_FLAG_CLEAR) && !statusQ[bitSel]);
        cycles = cycle_count(opcode, skipCond, branchTaken, nextTwoWord);
    end

    mfc_multiplier u_multiplier (
        .opA(srcA),
        .opB(srcB),
        .signedA(mulSignedA),
        .signedB(mulSignedB),
        .fractional(mulFrac),
        .rawProduct(mulRaw),
        .result(mulResult),
        .carryOut(mulC),
        .zeroOut(mulZ)
    );

    mfc_comparator u_comparator (
        .minuend(srcA),
        .subtrahend(cmpB),
        .borrowIn(cmpBorrow),
        .flagH(cmpH),
        .flagV(cmpV),
        .flagN(cmpN),
        .flagZ(cmpZ),
        .flagC(cmpC)
    );

    // Sequencing of multi-cycle instructions
    always_comb
    begin
        stateD = stateQ;
        cntD = cntQ;
        doneD = 1'b0;
        case (stateQ)
            mfc_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    if (cycles == `CYC_SINGLE)
                    begin
                        doneD = 1'b1;
                    end
                    else
                    begin
                        stateD = mfc_pkg::ST_EXEC;
                        cntD = cycles[1:0] - 2'h1;
                    end
                end
            end
            mfc_pkg::ST_EXEC:
            begin
                cntD = cntQ - 2'h1;
                if (cntQ == 2'h1)
                begin
                    stateD = mfc_pkg::ST_IDLE;
                    doneD = 1'b1;
                end
            end
            default:
            begin
                stateD = mfc_pkg::ST_IDLE;
                cntD = 2'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateQ <= mfc_pkg::ST_IDLE;
            cntQ <= 2'h0;
            doneQ <= 1'b0;
        end
        else
        begin
            stateQ <= stateD;
            cntQ <= cntD;
            doneQ <= doneD;
        end
    end

    // Program counter, flags, product and stack effects
    always_comb
    begin
        pcD = pcQ;
        statusD = statusQ;
        productD = productQ;
        productWriteD = 1'b0;
        pushAddrD = pushAddrQ;
        pushD = 1'b0;
        popD = 1'b0;
        if (accept)
        begin
            pcD = pcQ + `PC_STEP_ONE;
            case (opcode)
                mfc_pkg::RELATIVE_JUMP: pcD = pcQ + offsetExt + `PC_STEP_ONE;
                mfc_pkg::POINTER_JUMP: pcD = zPointer;
                mfc_pkg::ABSOLUTE_JUMP: pcD = absTarget;
                mfc_pkg::RELATIVE_SUBROUTINE_CALL:
                begin
                    pcD = pcQ + offsetExt + `PC_STEP_ONE;
                    pushAddrD = pcQ + `PC_STEP_ONE;
                    pushD = 1'b1;
                end
                mfc_pkg::POINTER_SUBROUTINE_CALL:
                begin
                    pcD = zPointer;
                    pushAddrD = pcQ + `PC_STEP_ONE;
                    pushD = 1'b1;
                end
                mfc_pkg::ABSOLUTE_SUBROUTINE_CALL:
                begin
                    pcD = absTarget;
                    pushAddrD = pcQ + `PC_STEP_TWO;
                    pushD = 1'b1;
                end
                mfc_pkg::SUBROUTINE_RETURN:
                begin
                    pcD = stackData;
                    popD = 1'b1;
                end
                mfc_pkg::INTERRUPT_RETURN:
                begin
                    pcD = stackData;
                    popD = 1'b1;
                    statusD[`FLAG_I] = 1'b1;
                end
                mfc_pkg::REGISTER_COMPARE, mfc_pkg::REGISTER_COMPARE_WITH_CARRY,
                mfc_pkg::IMMEDIATE_COMPARE:
                begin
                    statusD[`FLAG_H] = cmpH;
                    statusD[`FLAG_V] = cmpV;
                    statusD[`FLAG_N] = cmpN;
                    statusD[`FLAG_S] = cmpN ^ cmpV;
                    statusD[`FLAG_C] = cmpC;
                    statusD[`FLAG_Z] = (opcode == mfc_pkg::REGISTER_COMPARE_WITH_CARRY)
                        ? (cmpZ && statusQ[`FLAG_Z]) : cmpZ;
                end
                mfc_pkg::BRANCH_FLAG_SET, mfc_pkg::BRANCH_FLAG_CLEAR:
                begin
                    if (branchTaken)
                    begin
                        pcD = pcQ + offsetExt + `PC_STEP_ONE;
                    end
                end
                default:
                begin
                    if (skipCond)
                    begin
                        pcD = pcQ + (nextTwoWord ? `PC_STEP_THREE : `PC_STEP_TWO);
                    end
                    if (isMul)
                    begin
                        productD = mulResult;
                        productWriteD = 1'b1;
                        statusD[`FLAG_C] = mulC;
                        statusD[`FLAG_Z] = mulZ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcQ <= `PC_RESET;
            statusQ <= `STATUS_RESET;
            productQ <= `PRODUCT_RESET;
            productWriteQ <= 1'b0;
            pushAddrQ <= `PC_RESET;
            pushQ <= 1'b0;
            popQ <= 1'b0;
        end
        else
        begin
            pcQ <= pcD;
            statusQ <= statusD;
            productQ <= productD;
            productWriteQ <= productWriteD;
            pushAddrQ <= pushAddrD;
            pushQ <= pushD;
            popQ <= popD;
        end
    end

    always_comb
    begin
        busy = (stateQ == mfc_pkg::ST_EXEC);
        done = doneQ;
        pcOut = pcQ;
        statusOut = statusQ;
        productOut = productQ;
        productWrite = productWriteQ;
        pushAddr = pushAddrQ;
        pushStrobe = pushQ;
        popStrobe = popQ;
    end

    sequence s_two_cycle;
        busy && !done ##1 !busy && done;
    endsequence

    sequence s_three_cycle;
        busy[*2] ##1 !busy && done;
    endsequence

    a_mul_product: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && isMul && !mulFrac |=> productWrite && productOut == $past(mulRaw)
        ##0 s_two_cycle)
        else $error("integer multiply product or timing wrong");

    a_frac_shift: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && mulFrac |=> productOut == {$past(mulRaw[14:0]), 1'b0} ##0 s_two_cycle)
        else $error("fractional multiply not shifted or late");

    a_mul_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && isMul |=> statusOut[`FLAG_C] == $past(mulRaw[15])
        && statusOut[`FLAG_Z] == (productOut == 16'h0000))
        else $error("multiply flags wrong");

    a_ptr_jump: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::POINTER_JUMP |=> pcOut == $past(zPointer)
        && statusOut == $past(statusOut) ##0 s_two_cycle)
        else $error("pointer jump wrong");

    a_ptr_call: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::POINTER_SUBROUTINE_CALL |=> pushStrobe
        && pushAddr == $past(pcOut) + `PC_STEP_ONE && pcOut == $past(zPointer) ##0 s_three_cycle)
        else $error("pointer call wrong");

    a_skip_equal: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::COMPARE_SKIP_EQUAL && srcA == srcB && !nextTwoWord
        |=> pcOut == $past(pcOut) + `PC_STEP_TWO ##0 s_two_cycle)
        else $error("compare skip wrong");

    a_reg_skip: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::SKIP_REG_BIT_CLEAR && !srcB[bitSel] && nextTwoWord
        |=> pcOut == $past(pcOut) + `PC_STEP_THREE && statusOut == $past(statusOut)
        ##0 s_three_cycle)
        else $error("register bit skip wrong");

    a_io_noskip: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::SKIP_IO_BIT_SET && !ioData[bitSel]
        |=> pcOut == $past(pcOut) + `PC_STEP_ONE && done && !busy)
        else $error("io bit skip wrong");

    a_branch_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::BRANCH_FLAG_SET && statusOut[bitSel]
        |=> pcOut == $past(pcOut) + $past(offsetExt) + `PC_STEP_ONE ##0 s_two_cycle)
        else $error("taken branch wrong");

    a_branch_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::BRANCH_FLAG_CLEAR && statusOut[bitSel]
        |=> pcOut == $past(pcOut) + `PC_STEP_ONE && done && statusOut == $past(statusOut))
        else $error("untaken branch wrong");

    a_cmp_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::IMMEDIATE_COMPARE |=> !productWrite && done
        && statusOut[`FLAG_C] == ($past(srcA) < $past(immK))
        && statusOut[`FLAG_Z] == ($past(srcA) == $past(immK)))
        else $error("compare flags wrong");

    a_int_return: assert property (@(posedge sys_clk) disable iff (!arst_n)
        accept && opcode == mfc_pkg::INTERRUPT_RETURN |=> statusOut[`FLAG_I] && popStrobe
        && pcOut == $past(stackData) ##0 busy[*3] ##1 done)
        else $error("interrupt return wrong");
endmodule

//--- verification/multiply_and_flow_control_tb.sv
// Self-checking bench for the multiply and program-flow execution block.
// Assumes the rtl package and header compile first; the bench drives every port.
`timescale 1ns/100ps
module multiply_and_flow_control_tb;
    logic sys_clk, arst_n, instrValid, nextTwoWord;
    mfc_pkg::opcode_e opcode;
    logic [7:0] srcA, srcB, immK, ioData, statusOut, eS, sub, r;
    logic [2:0] bitSel;
    logic [11:0] relOffset;
    logic [15:0] absTarget, zPointer, stackData, pcOut, productOut, pushAddr;
    logic [15:0] eP, eProd, ePush, raw, nxt, absolute_jump;
    logic busy, done, productWrite, pushStrobe, popStrobe, cond, sA, sB;
    int err_total, check_count, eCyc, ePushN, ePopN, eProdN;

    multiply_and_flow_control i_dut (.sys_clk, .arst_n, .instrValid, .opcode, .srcA, .srcB,
        .immK, .bitSel, .ioData, .relOffset, .absTarget, .zPointer, .stackData,
        .nextTwoWord, .busy, .done, .pcOut, .statusOut, .productOut, .productWrite,
        .pushAddr, .pushStrobe, .popStrobe);

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic void predict();
        nxt = eP + 16'h0001;
        absolute_jump = eP + {{4{relOffset[11]}}, relOffset} + 16'h0001;
        eCyc = 1;
        ePushN = 0;
        ePopN = 0;
        eProdN = 0;
        ePush = nxt;
        eP = nxt;
        sA = opcode inside {5'h02, 5'h03, 5'h05, 5'h06};
        sB = opcode inside {5'h02, 5'h05};
        sub = (opcode == mfc_pkg::IMMEDIATE_COMPARE) ? immK : srcB;
        r = srcA - sub - ((opcode == mfc_pkg::REGISTER_COMPARE_WITH_CARRY) ? eS[0] : 1'b0);
        cond = 1'b0;
        case (opcode)
            5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
            begin
                raw = 16'($signed({sA & srcA[7], srcA}) * $signed({sB & srcB[7], srcB}));
                eProd = (opcode > 5'h03) ? {raw[14:0], 1'b0} : raw;
                eS[0] = raw[15];
                eS[1] = (eProd == 16'h0000);
                eCyc = 2;
                eProdN = 1;
            end
            mfc_pkg::RELATIVE_JUMP: {eP, eCyc} = {absolute_jump, 32'd2};
            mfc_pkg::POINTER_JUMP: {eP, eCyc} = {zPointer, 32'd2};
            mfc_pkg::ABSOLUTE_JUMP: {eP, eCyc} = {absTarget, 32'd3};
            mfc_pkg::RELATIVE_SUBROUTINE_CALL: {eP, eCyc, ePushN} = {absolute_jump, 32'd3, 32'd1};
            mfc_pkg::POINTER_SUBROUTINE_CALL: {eP, eCyc, ePushN} = {zPointer, 32'd3, 32'd1};
            mfc_pkg::ABSOLUTE_SUBROUTINE_CALL:
                {eP, eCyc, ePushN, ePush} = {absTarget, 32'd4, 32'd1, nxt + 16'h0001};
            mfc_pkg::SUBROUTINE_RETURN, mfc_pkg::INTERRUPT_RETURN:
            begin
                {eP, eCyc, ePopN} = {stackData, 32'd4, 32'd1};
                if (opcode == mfc_pkg::INTERRUPT_RETURN)
                    eS[7] = 1'b1;
            end
            5'h10, 5'h11, 5'h12:
            begin
                eS[5] = (~srcA[3] & sub[3]) | (sub[3] & r[3]) | (r[3] & ~srcA[3]);
                eS[3] = (srcA[7] & ~sub[7] & ~r[7]) | (~srcA[7] & sub[7] & r[7]);
                eS[2] = r[7];
                eS[4] = r[7] ^ eS[3];
                eS[1] = (r == 8'h00) & ((opcode == 5'h11) ? eS[1] : 1'b1);
                eS[0] = (~srcA[7] & sub[7]) | (sub[7] & r[7]) | (r[7] & ~srcA[7]);
            end
            5'h0F, 5'h13, 5'h14, 5'h15, 5'h16:
            begin
                cond = (opcode == 5'h0F) ? (srcA == srcB) :
                    (((opcode < 5'h15) ? srcB[bitSel] : ioData[bitSel]) != opcode[0]);
                if (cond)
                    {eP, eCyc} = {eP + (nextTwoWord ? 16'h0002 : 16'h0001), nextTwoWord + 32'd2};
            end
            5'h17, 5'h18:
                if (eS[bitSel] == (opcode == mfc_pkg::BRANCH_FLAG_SET))
                    {eP, eCyc} = {absolute_jump, 32'd2};
            default: eP = nxt;
        endcase
    endfunction

    task automatic run_one();
        int n, pu, po, pw;
        {n, pu, po, pw} = '0;
        predict();
        instrValid = 1'b1;
        @(posedge sys_clk);
        while (n < 8)
        begin
            @(negedge sys_clk);
            n++;
            pu += (pushStrobe === 1'b1);
            po += (popStrobe === 1'b1);
            pw += (productWrite === 1'b1);
            if (pushStrobe === 1'b1) chk("return address", ePush, pushAddr);
            if (done === 1'b1) break;
            chk("busy", 16'(n < eCyc), 16'(busy));
        end
        chk("cycles", 16'(eCyc), 16'(n));
        chk("pc", eP, pcOut);
        chk("status", 16'(eS), 16'(statusOut));
        chk("product", eProd, productOut);
        chk("pulses", 16'(ePushN * 16 + ePopN * 4 + eProdN), 16'(pu * 16 + po * 4 + pw));
    endtask

    task automatic rand_ops(input logic [4:0] op);
        opcode = mfc_pkg::opcode_e'(op);
        {srcA, srcB, immK, ioData, bitSel, relOffset} = 47'($urandom) ^ {$urandom, 15'h0000};
        {absTarget, zPointer, stackData, nextTwoWord} = 49'({$urandom, $urandom});
    endtask

    task automatic go(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b);
        rand_ops(op);
        {srcA, srcB} = {a, b};
        run_one();
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        instrValid = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("reset outputs", 16'h0000, pcOut | productOut | statusOut | pushAddr
            | {busy, done, pushStrobe, popStrobe, productWrite});
        {eP, eS, eProd} = '0;
        arst_n = 1'b1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_total++;
        $display("watchdog expired");
        complete_run();
    end

    initial
    begin
        {err_total, check_count} = '0;
        void'($urandom(32'h0F21));
        rand_ops(5'h00);
        do_reset();
        go(5'h02, 8'h80, 8'h80);
        go(5'h05, 8'h80, 8'h80);
        go(5'h03, 8'hFF, 8'hFF);
        go(5'h04, 8'h00, 8'h37);
        go(5'h06, 8'h80, 8'hFF);
        go(5'h10, 8'h5A, 8'h5A);
        go(5'h11, 8'h5A, 8'h5A);
        go(5'h11, 8'h00, 8'h01);
        go(5'h0F, 8'h33, 8'h33);
        for (int i = 0; i < 600; i++)
        begin
            rand_ops(5'($urandom_range(0, 24)));
            if (i % 7 == 0) srcB = srcA;
            run_one();
        end
        rand_ops(5'h0C);
        instrValid = 1'b1;
        @(negedge sys_clk);
        do_reset();
        go(5'h0E, 8'h00, 8'h00);
        go(5'h17, 8'h00, 8'h00);
        complete_run();
    end
endmodule
